/* File: design/iosd_consts.svh */
// Constants for the I/O register space decoder: windows, offsets, reset values
`ifndef IOSD_CONSTS_SVH
`define IOSD_CONSTS_SVH

`define IOSD_PORT_LAST      8'h3F
`define IOSD_BIT_LAST       8'h1F
`define IOSD_DATA_OFFSET    8'h20
`define IOSD_EXT_FIRST      8'h60
`define IOSD_EXT_LAST       8'hFF
`define IOSD_SCR0_PORT      8'h1E
`define IOSD_SCR1_PORT      8'h1D
`define IOSD_SCR2_PORT      8'h1C
`define IOSD_FLAG_PORT      8'h1B
`define IOSD_EXT_SCR_DATA   8'h60
`define IOSD_SCR_RESET      8'h00
`define IOSD_FLAG_RESET     8'h00

`endif

/* File: design/iosd_pkg.sv */
// Types shared by the core-side and register-side ends of the I/O space
package iosd_pkg;

  // Access kinds that the core can issue
  typedef enum logic [6:0] {
    IOSD_OP_NONE    = 7'b0000001,
    IOSD_OP_PORT_RD = 7'b0000010,
    IOSD_OP_PORT_WR = 7'b0000100,
    IOSD_OP_MEM_RD  = 7'b0001000,
    IOSD_OP_MEM_WR  = 7'b0010000,
    IOSD_OP_BIT_SET = 7'b0100000,
    IOSD_OP_BIT_CLR = 7'b1000000
  } iosd_op_e;

  typedef logic [7:0] iosd_byte_t;

endpackage : iosd_pkg

/* File: design/iosd_if.sv */
// Interface carrying I/O space accesses from the core end to the register end
`timescale 1ns/100ps
interface iosd_if;
  iosd_pkg::iosd_op_e   op;
  iosd_pkg::iosd_byte_t addr;
  logic [2:0]           bit_sel;
  iosd_pkg::iosd_byte_t wdata;
  iosd_pkg::iosd_byte_t rdata;
  logic                 bit_val;
  logic                 err;

  modport core (output op, output addr, output bit_sel, output wdata,
                input rdata, input bit_val, input err);
  modport regs (input op, input addr, input bit_sel, input wdata,
                output rdata, output bit_val, output err);
endinterface : iosd_if

/* File: design/iosd_regs.sv */
// Register end of the I/O space: decode, scratch registers and a flag register
`timescale 1ns/100ps
`include "iosd_consts.svh"
module iosd_regs (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] flag_set_i,
  output logic      [7:0] flag_o,
  output logic      [7:0] ext_scratch_o,
  iosd_if.regs            bus
);

  //////////////////////////////////////////////////////////////////////////////
  // Address translation
  logic       is_port;
  logic       is_mem;
  logic       is_bit;
  logic [7:0] port_addr;
  logic       mem_in_io;
  logic       mem_in_ext;
  logic       addr_ok;
  logic       wr_any;

  assign is_port    = (bus.op == iosd_pkg::IOSD_OP_PORT_RD)
                    | (bus.op == iosd_pkg::IOSD_OP_PORT_WR);
  assign is_mem     = (bus.op == iosd_pkg::IOSD_OP_MEM_RD)
                    | (bus.op == iosd_pkg::IOSD_OP_MEM_WR);
  assign is_bit     = (bus.op == iosd_pkg::IOSD_OP_BIT_SET)
                    | (bus.op == iosd_pkg::IOSD_OP_BIT_CLR);
  // Data space maps 0x20..0x5F onto port 0x00..0x3F
  assign mem_in_io  = (bus.addr >= `IOSD_DATA_OFFSET)
                    & (bus.addr < `IOSD_EXT_FIRST);
  assign mem_in_ext = (bus.addr >= `IOSD_EXT_FIRST);
  assign port_addr  = is_mem ? bus.addr - `IOSD_DATA_OFFSET : bus.addr;
  // Port ops stop at 0x3F, bit ops at 0x1F, extended only by load/store
  assign addr_ok    = is_port ? (bus.addr <= `IOSD_PORT_LAST)
                    : is_bit  ? (bus.addr <= `IOSD_BIT_LAST)
                    : is_mem  ? (mem_in_io | mem_in_ext)
                    : 1'b0;
  function automatic logic mem_in_ext_sel();
    mem_in_ext_sel = is_mem & mem_in_ext;
  endfunction : mem_in_ext_sel

  assign wr_any     = addr_ok & ~mem_in_ext_sel() &
                      ((bus.op == iosd_pkg::IOSD_OP_PORT_WR)
                     | (bus.op == iosd_pkg::IOSD_OP_MEM_WR) | is_bit);

  //////////////////////////////////////////////////////////////////////////////
  // Register selection and write data
  logic [7:0] scr [3];
  logic [7:0] flag;
  logic [7:0] ext_scr;
  logic [7:0] cur;
  logic [7:0] bit_mask;
  logic [7:0] scr_new;
  logic [7:0] flag_clr;
  logic       sel_flag;
  logic       sel_ext;
  logic [2:0] sel_scr;

  function automatic logic [2:0] scr_hit(input logic [7:0] a);
    scr_hit = {a == `IOSD_SCR2_PORT, a == `IOSD_SCR1_PORT, a == `IOSD_SCR0_PORT};
  endfunction : scr_hit

  assign sel_scr  = addr_ok & ~mem_in_ext_sel() ? scr_hit(port_addr) : 3'h0;
  assign sel_flag = addr_ok & ~mem_in_ext_sel() & (port_addr == `IOSD_FLAG_PORT);
  assign sel_ext  = addr_ok & mem_in_ext_sel() & (bus.addr == `IOSD_EXT_SCR_DATA);
  assign bit_mask = 8'h01 << bus.bit_sel;
  assign cur      = sel_scr[0] ? scr[0] : sel_scr[1] ? scr[1] : sel_scr[2] ? scr[2]
                  : sel_flag ? flag : sel_ext ? ext_scr : 8'h00;
  // Bit ops modify one bit of the current value only
  assign scr_new  = (bus.op == iosd_pkg::IOSD_OP_BIT_SET) ? (cur | bit_mask)
                  : (bus.op == iosd_pkg::IOSD_OP_BIT_CLR) ? (cur & ~bit_mask)
                  : bus.wdata;
  // Flag writes: bit ops present only the addressed bit, so neighbours stay set
  assign flag_clr = ~(wr_any & sel_flag) ? 8'h00
                  : (bus.op == iosd_pkg::IOSD_OP_BIT_SET) ? bit_mask
                  : (bus.op == iosd_pkg::IOSD_OP_BIT_CLR) ? 8'h00
                  : bus.wdata;

  //////////////////////////////////////////////////////////////////////////////
  // Scratch registers, held until software writes them
  for (genvar g = 0; g < 3; g++)
  begin : g_scr
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
        scr[g] <= `IOSD_SCR_RESET;
      else if (wr_any & sel_scr[g])
        scr[g] <= scr_new;
    end
  end

  // Extended scratch, reachable by load/store only
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ext_scr <= `IOSD_SCR_RESET;
    else if (sel_ext & (bus.op == iosd_pkg::IOSD_OP_MEM_WR))
      ext_scr <= bus.wdata;
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flag <= `IOSD_FLAG_RESET;
    else
      flag <= (flag & ~flag_clr) | flag_set_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path: combinational, valid in the access cycle
  assign bus.rdata     = ((bus.op == iosd_pkg::IOSD_OP_PORT_RD)
                        | (bus.op == iosd_pkg::IOSD_OP_MEM_RD)) ? cur : 8'h00;
  assign bus.bit_val   = is_bit ? cur[bus.bit_sel] : 1'b0;
  assign bus.err       = (bus.op != iosd_pkg::IOSD_OP_NONE) & ~addr_ok;
  assign flag_o        = flag;
  assign ext_scratch_o = ext_scr;

endmodule : iosd_regs

/* File: design/iosd_core.sv */
// Core end of the I/O space: turns user commands into interface accesses
`timescale 1ns/100ps
`include "iosd_consts.svh"
module iosd_core (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                req_i,
  input  iosd_pkg::iosd_op_e       op_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [2:0]          bit_sel_i,
  input  wire logic [7:0]          wdata_i,
  output logic      [7:0]          rdata_o,
  output logic                     bit_val_o,
  output logic                     err_o,
  output logic                     done_o,
  iosd_if.core                     bus
);

  //////////////////////////////////////////////////////////////////////////////
  // Requests are passed through in the request cycle
  assign bus.op      = req_i ? op_i : iosd_pkg::IOSD_OP_NONE;
  assign bus.addr    = addr_i;
  assign bus.bit_sel = bit_sel_i;
  // Reserved bits are not masked here; software keeps them zero
  assign bus.wdata   = wdata_i;

  // Answers registered one cycle later
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o   <= 8'h00;
      bit_val_o <= 1'b0;
      err_o     <= 1'b0;
      done_o    <= 1'b0;
    end
    else
    begin
      rdata_o   <= bus.rdata;
      bit_val_o <= bus.bit_val;
      err_o     <= req_i & bus.err;
      done_o    <= req_i;
    end
  end

endmodule : iosd_core

/* File: verif/iosd_sva.sv */
// Checker for accesses on the link between the core end and the register end
`timescale 1ns/100ps
module iosd_sva (
  input wire logic            clk_i,
  input wire logic            arst_n_i,
  input iosd_pkg::iosd_op_e   op,
  input iosd_pkg::iosd_byte_t addr,
  input wire logic [2:0]      bit_sel,
  input iosd_pkg::iosd_byte_t wdata,
  input iosd_pkg::iosd_byte_t rdata,
  input wire logic            bit_val,
  input wire logic            err
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // One-hot op bits, so each property reads short
  wire pr = op[1];
  wire pw = op[2];
  wire mr = op[3];
  wire mw = op[4];
  wire bs = op[5];
  wire bc = op[6];
  ////////////////////////////////////////////////////////////////////////////
  // Windows and refusals, then aliasing and bit tests across two accesses
  property p_port; (pr || pw) && addr > 8'h3F |-> err; endproperty
  property p_bit; (bs || bc) && addr > 8'h1F |-> err; endproperty
  property p_mem; (mr || mw) && addr < 8'h20 |-> err; endproperty
  property p_ext; (mr || mw) && addr >= 8'h60 |-> !err; endproperty
  property p_zero; err |-> rdata == 8'h00; endproperty
  property p_alias; mw && addr == 8'h3E ##1 pr && addr == 8'h1E |-> rdata == $past(wdata);
  endproperty
  property p_last; pw && addr == 8'h1D ##1 mr && addr == 8'h3D |-> rdata == $past(wdata);
  endproperty
  property p_set; bs && addr == 8'h1C ##1 bc && addr == 8'h1C && bit_sel == $past(bit_sel)
    |-> bit_val; endproperty
  property p_clr; bc && addr == 8'h1C ##1 bs && addr == 8'h1C && bit_sel == $past(bit_sel)
    |-> !bit_val; endproperty
  a_port: assert property (p_port) else $error("port op out of range accepted");
  a_bit: assert property (p_bit) else $error("bit op out of range accepted");
  a_mem: assert property (p_mem) else $error("memory op below 0x20 accepted");
  a_ext: assert property (p_ext) else $error("extended access refused");
  a_zero: assert property (p_zero) else $error("refused access returned data");
  a_alias: assert property (p_alias) else $error("data address alias wrong");
  a_last: assert property (p_last) else $error("read not last written");
  a_set: assert property (p_set) else $error("bit set not seen");
  a_clr: assert property (p_clr) else $error("bit clear not seen");
  // Main scenarios reached
  c_ext: cover property (mw && addr == 8'h60);
  c_err: cover property (err);
  c_bit: cover property (bc && bit_val);
endmodule : iosd_sva

/* File: verif/io_register_space_decode_test.sv */
// Self-checking bench driving both ends of the I/O space link
`timescale 1ns/100ps
module io_register_space_decode_test;
  logic               clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic               req_i = 1'b0;
  iosd_pkg::iosd_op_e op_i = iosd_pkg::IOSD_OP_NONE;
  logic [7:0]         addr_i = 8'h00;
  logic [2:0]         bit_sel_i = 3'h0;
  logic [7:0]         wdata_i = 8'h00;
  logic [7:0]         flag_set_i = 8'h00;
  wire  [7:0]         rdata_o, flag_o, ext_scratch_o;
  wire                bit_val_o, err_o, done_o;
  int                 num_errors = 0;
  int                 checks_done = 0;
  integer             seed = 32'h86548e2b;
  logic [7:0]         mem [256];
  logic [7:0]         tbl [12] = '{8'h1C, 8'h1D, 8'h1E, 8'h3C, 8'h3D, 8'h3E, 8'h60, 8'h1F,
                                   8'h20, 8'h3F, 8'h40, 8'hFF};
  iosd_pkg::iosd_op_e ops [6] = '{iosd_pkg::IOSD_OP_PORT_RD, iosd_pkg::IOSD_OP_PORT_WR,
    iosd_pkg::IOSD_OP_MEM_RD, iosd_pkg::IOSD_OP_MEM_WR, iosd_pkg::IOSD_OP_BIT_SET,
    iosd_pkg::IOSD_OP_BIT_CLR};
  iosd_if bus ();
  iosd_core u_iosd_core (.clk_i, .arst_n_i, .req_i, .op_i, .addr_i, .bit_sel_i, .wdata_i,
    .rdata_o, .bit_val_o, .err_o, .done_o, .bus(bus));
  iosd_regs u_iosd_regs (.clk_i, .arst_n_i, .flag_set_i, .flag_o, .ext_scratch_o, .bus(bus));
  iosd_sva u_iosd_sva (.clk_i, .arst_n_i, .op(bus.op), .addr(bus.addr), .bit_sel(bus.bit_sel),
    .wdata(bus.wdata), .rdata(bus.rdata), .bit_val(bus.bit_val), .err(bus.err));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Reference: returns {refused, old bit, read byte}; the flag copy is write-one-to-clear
  function automatic logic [9:0] model(iosd_pkg::iosd_op_e o, logic [7:0] a, logic [2:0] b,
                                       logic [7:0] w);
    logic       e;
    logic [7:0] d;
    logic [7:0] v;
    e = (o[1] || o[2]) ? a > 8'h3F : (o[5] || o[6]) ? a > 8'h1F : a < 8'h20;
    d = (o[3] || o[4]) ? a : a + 8'h20;
    v = (d inside {8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h60}) ? mem[d] : 8'h00;
    if (!e && d == 8'h3B)
      mem[d] = (o[2] || o[4]) ? v & ~w : o[5] ? v & ~(8'h01 << b) : v;
    else if (!e && d inside {8'h3C, 8'h3D, 8'h3E, 8'h60})
      mem[d] = (o[2] || o[4]) ? w : o[5] ? v | (8'h01 << b) : o[6] ? v & ~(8'h01 << b) : v;
    return {e, v[b], e ? 8'h00 : v};
  endfunction : model
  task automatic chk_byte(logic [7:0] g, logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(logic g, logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask : chk_bit
  // Request held from one falling edge to the next; the answer is read one cycle on
  task automatic acc(iosd_pkg::iosd_op_e o, logic [7:0] a, logic [2:0] b, logic [7:0] w);
    logic [9:0] x;
    x = model(o, a, b, w);
    {req_i, op_i, addr_i, bit_sel_i, wdata_i} = {1'b1, o, a, b, w};
    @(negedge clk_i);
    chk_bit(done_o, 1'b1);
    chk_bit(err_o, x[9]);
    if (o[1] || o[3] || x[9]) chk_byte(rdata_o, x[7:0]);
    if ((o[5] || o[6]) && !x[9]) chk_bit(bit_val_o, x[8]);
  endtask : acc
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, directed corners back to back, flag clearing, then random traffic
  initial
  begin
    int j;
    int k;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 3; i++) acc(ops[0], 8'h1C + 8'(i), 3'h0, 8'h00);
    acc(ops[3], 8'h3E, 3'h0, 8'hA5);
    acc(ops[0], 8'h1E, 3'h0, 8'h00);
    acc(ops[1], 8'h1D, 3'h0, 8'h3C);
    acc(ops[2], 8'h3D, 3'h0, 8'h00);
    for (int i = 0; i < 3; i++) acc(ops[4 + i % 2], 8'h1C, 3'h7, 8'h00);
    acc(ops[3], 8'h60, 3'h0, 8'h77);
    acc(ops[0], 8'h40, 3'h0, 8'h00);
    acc(ops[2], 8'h60, 3'h0, 8'h00);
    chk_byte(ext_scratch_o, mem[8'h60]);
    req_i = 1'b0;
    flag_set_i = 8'h5A;
    mem[8'h3B] = 8'h5A;
    @(negedge clk_i);
    flag_set_i = 8'h00;
    acc(ops[1], 8'h1B, 3'h0, 8'h0A);
    acc(ops[4], 8'h1B, 3'h6, 8'h00);
    acc(ops[5], 8'h1B, 3'h4, 8'h00);
    chk_byte(flag_o, mem[8'h3B]);
    // Writes go only to real registers in the space they are issued in; reads go to any of the 12 table addresses
    repeat (400)
    begin
      j = $unsigned($random(seed)) % 12;
      k = $unsigned($random(seed)) % 6;
      if (k % 2 == 1 || k > 3) j = (k == 3) ? 3 + j % 4 : j % 3;
      // Target registers have no reserved bits, so any write byte is legal
      acc(ops[k], tbl[j], 3'($random(seed)), 8'($random(seed)));
    end
    req_i = 1'b0;
    chk_byte(ext_scratch_o, mem[8'h60]);
    close_out();
  end
  // About 416 accesses expected; nearly five times that cuts a hang short
  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule : io_register_space_decode_test
